// file: include/sflash_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sflash_if;
  logic sck;
  logic cs_n;
  logic [3:0] host_io;
  logic [3:0] host_io_oe_n;
  logic [3:0] dev_io;
  logic [3:0] dev_io_oe_n;
  wire [3:0] io;

  // ----------------------------------------------------------------
  // wire resolution; a line nobody drives is pulled high
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_line
    assign io[i] = !host_io_oe_n[i] ? host_io[i] : (!dev_io_oe_n[i] ? dev_io[i] : 1'b1);
  end

  modport host (output sck, output cs_n, output host_io, output host_io_oe_n, input io);
  modport device (input sck, input cs_n, input io, output dev_io, output dev_io_oe_n);
endinterface : sflash_if
`default_nettype wire

// file: include/sflash_pkg.sv
package sflash_pkg;
  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_QUAD_ID = 8'h94;
  localparam logic [7:0] CMD_JEDEC_ID = 8'h9f;
  localparam logic [7:0] CMD_ENTER_QPI = 8'h38;
  localparam logic [7:0] CMD_EXIT_QPI = 8'hff;
  localparam logic [7:0] CMD_WORD_READ = 8'he7;
  localparam logic [7:0] CMD_SET_WRAP = 8'h77;
  localparam logic [7:0] CMD_WRAP_READ = 8'h0c;
  localparam logic [7:0] CMD_FAST_READ = 8'h0b;
  localparam logic [7:0] CMD_SET_PARAM = 8'hc0;
  localparam logic [3:0] CONT_READ_KEY = 4'ha;
  // ----------------------------------------------------------------
  // identity values (arbitrary, neutral)
  // ----------------------------------------------------------------
  localparam logic [7:0] MFR_ID_DEF = 8'h5a;
  localparam logic [7:0] DEV_ID_DEF = 8'h3c;
  localparam logic [7:0] MEM_TYPE_DEF = 8'h42;
  localparam logic [7:0] CAPACITY_DEF = 8'h16;
  localparam logic [7:0] DATA_SEED = 8'ha5;
  // ----------------------------------------------------------------
  // clock counts per phase
  // ----------------------------------------------------------------
  localparam logic [4:0] CMD_CLKS_SPI = 5'd8;
  localparam logic [4:0] CMD_CLKS_QPI = 5'd2;
  localparam logic [4:0] ADDR_CLKS = 5'd6;
  localparam logic [4:0] BYTE_CLKS_QUAD = 5'd2;
  localparam logic [4:0] WORD_READ_DUMMY = 5'd2;
  localparam logic [4:0] DUMMY_SHORT = 5'd4;
  localparam logic [4:0] DUMMY_LONG = 5'd6;
  // ----------------------------------------------------------------
  // field layouts and reset values
  // ----------------------------------------------------------------
  localparam int WRAP_BITS_LSB = 4;
  localparam int DUMMY_SEL_LSB = 4;
  localparam int WRAP_SEL_LSB = 0;
  localparam logic [2:0] WRAP_SETTING_RST = 3'b001;
  localparam logic [1:0] DUMMY_SEL_RST = 2'b00;
  localparam logic [1:0] WRAP_SEL_RST = 2'b00;
  localparam logic [1:0] DUMMY_SEL_LONG = 2'b10;
  // ----------------------------------------------------------------
  // link timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCK_PERIOD_NS = 160;
  localparam int SCK_HALF_CYCLES = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_CMD = 3'b001,
    PH_ADDR = 3'b010,
    PH_MODE = 3'b011,
    PH_DUMMY = 3'b100,
    PH_DATA = 3'b101,
    PH_DONE = 3'b110
  } ph_type;
endpackage : sflash_pkg

// file: testbench/serial_flash_id_mode_wrap_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module serial_flash_id_mode_wrap_ctrl_test;
  import sflash_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic quad_en = 1'b0;
  logic start = 1'b0;
  logic [7:0] op_cmd = 8'h00;
  logic op_qpi = 1'b0;
  logic op_skip = 1'b0;
  logic op_ha = 1'b0;
  logic [23:0] op_addr = 24'h000000;
  logic op_hx = 1'b0;
  logic [7:0] op_xb = 8'h00;
  logic [3:0] op_dm = 4'h0;
  logic [7:0] op_nb = 8'h00;
  logic op_rq = 1'b0;
  logic busy, rd_valid, qpi_mode, execute_in_place;
  logic [7:0] rd_data;
  logic [2:0] wrap_bits;
  logic [1:0] dsel, wsel;
  logic [7:0] rx [64];
  logic [7:0] jid [3];
  int rxn;
  int err_count = 0;
  int compares = 0;

  always #(CLK_PERIOD_NS / 2) clk_sys_i = ~clk_sys_i;

  sflash_if link();
  sflash_host #(.HALF_CYCLES(SCK_HALF_CYCLES)) i_sflash_host (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .link(link), .start_i(start), .op_cmd_i(op_cmd), .op_qpi_i(op_qpi),
    .op_skip_cmd_i(op_skip), .op_has_addr_i(op_ha), .op_addr_i(op_addr),
    .op_has_xbyte_i(op_hx), .op_xbyte_i(op_xb), .op_dummy_i(op_dm), .op_nbytes_i(op_nb),
    .op_rd_quad_i(op_rq), .busy_o(busy), .rd_data_o(rd_data), .rd_valid_o(rd_valid));
  sflash_dev i_sflash_dev (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(link),
    .quad_io_enable_bit_i(quad_en), .four_line_command_mode_o(qpi_mode),
    .execute_in_place_o(execute_in_place), .wrap_setting_bits_o(wrap_bits),
    .dummy_count_select_o(dsel), .wrap_size_select_o(wsel));
  sflash_link_props #(.HALF_CYCLES(SCK_HALF_CYCLES)) i_sflash_link_props (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .sck_i(link.sck), .cs_n_i(link.cs_n),
    .host_io_i(link.host_io), .host_io_oe_n_i(link.host_io_oe_n),
    .dev_io_i(link.dev_io), .dev_io_oe_n_i(link.dev_io_oe_n));

  // ----------------------------------------------------------------
  // checking and transfer tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic op(input logic [7:0] c, input logic q, input logic s, input logic h,
                    input logic [23:0] ad, input logic x, input logic [7:0] xb,
                    input logic [3:0] dm, input logic [7:0] nb, input logic rq);
    int g;
    g = 0;
    rxn = 0;
    @(negedge clk_sys_i);
    op_cmd = c;
    op_qpi = q;
    op_skip = s;
    op_ha = h;
    op_addr = ad;
    op_hx = x;
    op_xb = xb;
    op_dm = dm;
    op_nb = nb;
    op_rq = rq;
    start = 1'b1;
    @(negedge clk_sys_i);
    start = 1'b0;
    do begin
      @(posedge clk_sys_i);
      #1;
      if (rd_valid === 1'b1 && rxn < 64) begin
        rx[rxn] = rd_data;
        rxn++;
      end
      g++;
    end while (busy !== 1'b0 && g < 4000);
    if (busy !== 1'b0) begin
      err_count++;
      $display("[FAIL] %0t transfer did not finish", $time);
    end
    chk(8'(rxn), nb);
    // device wants chip select high for a few cycles between transfers
    repeat (6) @(negedge clk_sys_i);
  endtask : op

  // len 0 means a straight read with no wrap
  task automatic check_read(input logic [7:0] a0, input logic [7:0] len, input int n);
    logic [7:0] a;
    for (int i = 0; i < n; i++) begin
      a = (len == 8'h00) ? a0 + 8'(i) : ((a0 & ~(len - 8'h01)) | ((a0 + 8'(i)) & (len - 8'h01)));
      chk(rx[i], a ^ DATA_SEED);
    end
  endtask : check_read

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  initial begin
    // about five times the length of the whole sequence
    repeat (40000) @(posedge clk_sys_i);
    err_count++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    jid = '{MFR_ID_DEF, MEM_TYPE_DEF, CAPACITY_DEF};
    repeat (5) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    chk(8'(qpi_mode), 8'h00);
    chk(8'(wrap_bits), 8'h01);
    chk(8'(dsel), 8'h00);
    chk(8'(wsel), 8'h00);
    op(CMD_JEDEC_ID, 0, 0, 0, 24'h0, 0, 8'h00, 4'd0, 8'd6, 0);
    for (int i = 0; i < 6; i++) chk(rx[i], jid[i % 3]);
    for (int a = 0; a < 2; a++) begin
      op(CMD_QUAD_ID, 0, 0, 1, 24'(a), 0, 8'h00, 4'd0, 8'd5, 1);
      for (int i = 0; i < 5; i++) chk(rx[i], ((i + a) % 2) ? DEV_ID_DEF : MFR_ID_DEF);
    end
    op(CMD_SET_PARAM, 0, 0, 0, 24'h0, 1, 8'h21, 4'd0, 8'd0, 0);
    chk(8'({dsel, wsel}), 8'h00);
    op(CMD_ENTER_QPI, 0, 0, 0, 24'h0, 0, 8'h00, 4'd0, 8'd0, 0);
    chk(8'(qpi_mode), 8'h00);
    op(CMD_WORD_READ, 0, 0, 1, 24'h000010, 1, 8'ha0, 4'd2, 8'd0, 0);
    chk(8'(execute_in_place), 8'h00);
    op(CMD_SET_WRAP, 0, 0, 1, 24'h0, 1, 8'h00, 4'd0, 8'd0, 0);
    chk(8'(wrap_bits), 8'h01);
    @(negedge clk_sys_i) quad_en = 1'b1;
    for (int c = 0; c < 4; c++) begin
      op(CMD_SET_WRAP, 0, 0, 1, 24'h0, 1, {1'b1, 2'(c), 5'h0f}, 4'd0, 8'd0, 0);
      chk(8'(wrap_bits), 8'({2'(c), 1'b0}));
      op(CMD_WORD_READ, 0, 0, 1, 24'(64 + (8 << c) - 2), 1, 8'h0f, 4'd2, 8'd3, 1);
      check_read(8'h40 + 8'(8 << c) - 8'h02, 8'(8 << c), 3);
      chk(8'(execute_in_place), 8'h00);
    end
    op(CMD_SET_WRAP, 0, 0, 1, 24'h0, 1, 8'h10, 4'd0, 8'd0, 0);
    chk(8'(wrap_bits), 8'h01);
    op(CMD_WORD_READ, 0, 0, 1, 24'h00003e, 1, 8'h00, 4'd2, 8'd3, 1);
    check_read(8'h3e, 8'h00, 3);
    op(CMD_WORD_READ, 0, 0, 1, 24'h000010, 1, 8'ha3, 4'd2, 8'd2, 1);
    chk(8'(execute_in_place), 8'h01);
    op(8'h00, 0, 1, 1, 24'h000024, 1, 8'h50, 4'd2, 8'd2, 1);
    check_read(8'h24, 8'h00, 2);
    chk(8'(execute_in_place), 8'h00);
    op(CMD_SET_WRAP, 0, 0, 1, 24'h0, 1, 8'h20, 4'd0, 8'd0, 0);
    op(CMD_ENTER_QPI, 0, 0, 0, 24'h0, 0, 8'h00, 4'd0, 8'd0, 0);
    chk(8'(qpi_mode), 8'h01);
    chk(8'(wrap_bits), 8'h02);
    op(CMD_SET_PARAM, 1, 0, 0, 24'h0, 1, 8'h21, 4'd0, 8'd0, 0);
    chk(8'({dsel, wsel}), 8'h09);
    op(CMD_WRAP_READ, 1, 0, 1, 24'h00000e, 0, 8'h00, 4'd6, 8'd3, 1);
    check_read(8'h0e, 8'd16, 3);
    op(CMD_FAST_READ, 1, 0, 1, 24'h00000e, 0, 8'h00, 4'd6, 8'd3, 1);
    check_read(8'h0e, 8'h00, 3);
    op(CMD_EXIT_QPI, 1, 0, 0, 24'h0, 0, 8'h00, 4'd0, 8'd0, 0);
    chk(8'(qpi_mode), 8'h00);
    chk(8'(wrap_bits), 8'h02);
    // system reset with wrapping on restores wrapping off, then the host writes wrapping off again
    @(negedge clk_sys_i) rst_i = 1'b1;
    repeat (5) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    chk(8'(qpi_mode), 8'h00);
    chk(8'(wrap_bits), 8'h01);
    op(CMD_SET_WRAP, 0, 0, 1, 24'h0, 1, 8'h10, 4'd0, 8'd0, 0);
    chk(8'(wrap_bits), 8'h01);
    op(CMD_WORD_READ, 0, 0, 1, 24'h00003e, 1, 8'h00, 4'd2, 8'd3, 1);
    check_read(8'h3e, 8'h00, 3);
    give_verdict();
  end
endmodule : serial_flash_id_mode_wrap_ctrl_test
`default_nettype wire

// file: testbench/sflash_link_props.sv
`timescale 1ns/1ps
`default_nettype none
module sflash_link_props #(
  parameter int HALF_CYCLES = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic [3:0] host_io_i,
  input wire logic [3:0] host_io_oe_n_i,
  input wire logic [3:0] dev_io_i,
  input wire logic [3:0] dev_io_oe_n_i
);
  logic [7:0] hi_cnt_q;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // serial clock high time, counted in system cycles
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !sck_i) begin
      hi_cnt_q <= 8'h00;
    end else begin
      hi_cnt_q <= hi_cnt_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // link relations
  // ----------------------------------------------------------------
  a_sck_half_high: assert property ($fell(sck_i) |-> hi_cnt_q == 8'(HALF_CYCLES))
    else $error("serial clock high phase has wrong length");
  a_sck_idle_low: assert property (cs_n_i [*2] |-> !sck_i)
    else $error("serial clock moves while deselected");
  a_first_rise_setup: assert property ($fell(cs_n_i) |-> !sck_i [*3])
    else $error("serial clock rises too soon after select");
  a_host_data_stable: assert property (!cs_n_i && !$stable(host_io_i) |-> !sck_i)
    else $error("host data changed while serial clock high");
  a_dev_drive_falling: assert property (!$stable(dev_io_i) && dev_io_oe_n_i != 4'hf |-> !sck_i)
    else $error("device data changed while serial clock high");
  a_host_drives_cmd: assert property ($fell(cs_n_i) |-> !host_io_oe_n_i[0])
    else $error("host not driving line 0 at start of command");
  // device must stay off the lines for the first eight system cycles after select
  a_cmd_dev_quiet: assert property ($fell(cs_n_i) |-> (dev_io_oe_n_i == 4'hf) [*8])
    else $error("device drives during command phase");
  a_no_line_clash: assert property (((~host_io_oe_n_i) & (~dev_io_oe_n_i)) == 4'h0)
    else $error("host and device drive the same line");
  a_cs_release_dev: assert property ($rose(cs_n_i) |-> ##[0:6] dev_io_oe_n_i == 4'hf)
    else $error("device keeps driving after deselect");
endmodule : sflash_link_props
`default_nettype wire

// file: verilog/sflash_dev.sv
// Function
// - quad id: 1-line cmd, 6 quad address clocks
// - address bit0 picks manufacturer or device first
// - id bytes alternate until chip select rises
// - standard id: manufacturer, type, capacity, msb first
// - standard id repeats until chip select rises
// - only enter command switches into four-line mode
// - enter ignored unless quad enable set
// - single-line command mode after reset
// - entering keeps latch, suspend, wrap setting
// - exit command returns single-line, keeps settings
// - word read needs quad enable, two dummies
// - eight mode bits, lines released until data
// - mode nibble a skips next command byte
// - wrap setup: quad enable, 24 dummy, 8 wrap
// - disable bit clear: 8/16/32/64 byte wrap
// - wrapped output loops inside aligned section
// - wrap setting sticks; disable bit resets set
// - host rewrites wrap setting after system reset
// - four-line wrap read wraps; fast read does not
// - wrap read uses read-parameter length, dummies
// - read parameters reset to 8 bytes, 4 dummies
// - read-parameter command refused in single-line
`timescale 1ns/1ps
`default_nettype none
module sflash_dev
  import sflash_pkg::*;
#(
  parameter logic [7:0] MFR_ID = MFR_ID_DEF,
  parameter logic [7:0] DEV_ID = DEV_ID_DEF,
  parameter logic [7:0] MEM_TYPE = MEM_TYPE_DEF,
  parameter logic [7:0] CAPACITY = CAPACITY_DEF
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  sflash_if.device link,
  input wire logic quad_io_enable_bit_i,
  output logic four_line_command_mode_o,
  output logic execute_in_place_o,
  output logic [2:0] wrap_setting_bits_o,
  output logic [1:0] dummy_count_select_o,
  output logic [1:0] wrap_size_select_o
);
  typedef struct packed {
    logic sck_m;
    logic sck_r;
    logic sck_p;
    logic cs_m;
    logic cs_r;
    logic [3:0] io_m;
    logic [3:0] io_r;
    ph_type ph;
    logic [7:0] cmd;
    logic [23:0] addr;
    logic [4:0] cnt;
    logic [7:0] sh_in;
    logic [7:0] sh_out;
    logic [2:0] ucnt;
    logic [1:0] sel;
    logic [3:0] io_out;
    logic [3:0] oe_n;
    logic four_line_command_mode;
    logic cont;
    logic [2:0] wrap;
    logic [1:0] dsel;
    logic [1:0] wsel;
  } dev_state_type;

  dev_state_type s_q, s_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [23:0] step_addr(logic [23:0] a, logic wrap_en, logic [1:0] len);
    logic [7:0] m;
    logic [7:0] inc;
    m = 8'h3f >> (2'd3 - len);
    inc = a[7:0] + 8'h01;
    if (wrap_en) begin
      step_addr = {a[23:8], (a[7:0] & ~m) | (inc & m)};
    end else begin
      step_addr = a + 24'h000001;
    end
  endfunction : step_addr

  logic rise;
  logic fall;
  logic single;
  logic [7:0] nb;
  logic [7:0] cur_byte;
  logic [23:0] na;
  logic wrap_en;
  logic [1:0] wrap_len;

  assign rise = s_q.sck_r & ~s_q.sck_p;
  assign fall = ~s_q.sck_r & s_q.sck_p;
  // standard id in single-line mode is the only one-line output
  assign single = (s_q.cmd == CMD_JEDEC_ID) && !s_q.four_line_command_mode;
  assign nb = (s_q.four_line_command_mode || s_q.ph != PH_CMD) ? {s_q.sh_in[3:0], s_q.io_r} :
                                              {s_q.sh_in[6:0], s_q.io_r[0]};
  assign na = {s_q.addr[19:0], s_q.io_r};

  always_comb begin
    wrap_en = 1'b0;
    wrap_len = s_q.wsel;
    if (s_q.cmd == CMD_WORD_READ) begin
      wrap_en = ~s_q.wrap[0];
      wrap_len = s_q.wrap[2:1];
    end else if (s_q.cmd == CMD_WRAP_READ) begin
      wrap_en = 1'b1;
    end
    case (s_q.cmd)
      CMD_JEDEC_ID: cur_byte = (s_q.sel == 2'd0) ? MFR_ID :
                               ((s_q.sel == 2'd1) ? MEM_TYPE : CAPACITY);
      CMD_QUAD_ID: cur_byte = s_q.sel[0] ? DEV_ID : MFR_ID;
      default: cur_byte = s_q.addr[7:0] ^ DATA_SEED;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.sck_m = link.sck;
    s_d.sck_r = s_q.sck_m;
    s_d.sck_p = s_q.sck_r;
    s_d.cs_m = link.cs_n;
    s_d.cs_r = s_q.cs_m;
    s_d.io_m = link.io;
    s_d.io_r = s_q.io_m;
    if (s_q.cs_r) begin
      s_d.ph = PH_IDLE;
      s_d.oe_n = 4'hf;
      // a read cut mid-byte must not leave a half unit for the next selection
      s_d.ucnt = 3'd0;
    end else if (s_q.ph == PH_IDLE) begin
      if (s_q.cont) begin
        s_d.ph = PH_ADDR;
        s_d.cmd = CMD_WORD_READ;
        s_d.cnt = ADDR_CLKS;
      end else begin
        s_d.ph = PH_CMD;
        s_d.cnt = s_q.four_line_command_mode ? CMD_CLKS_QPI : CMD_CLKS_SPI;
      end
    end else if (rise) begin
      s_d.cnt = s_q.cnt - 5'd1;
      s_d.sh_in = nb;
      case (s_q.ph)
        PH_CMD: begin
          if (s_q.cnt == 5'd1) begin
            s_d.cmd = nb;
            s_d.ph = PH_DONE;
            s_d.sel = 2'd0;
            s_d.ucnt = 3'd0;
            s_d.cnt = ADDR_CLKS;
            case (nb)
              CMD_JEDEC_ID: s_d.ph = PH_DATA;
              CMD_QUAD_ID: if (!s_q.four_line_command_mode) s_d.ph = PH_ADDR;
              // only the mode flag moves; latch, suspend and wrap stay put
              CMD_ENTER_QPI: if (quad_io_enable_bit_i) s_d.four_line_command_mode = 1'b1;
              CMD_EXIT_QPI: if (s_q.four_line_command_mode) s_d.four_line_command_mode = 1'b0;
              CMD_WORD_READ: if (quad_io_enable_bit_i) s_d.ph = PH_ADDR;
              CMD_SET_WRAP: if (quad_io_enable_bit_i) s_d.ph = PH_ADDR;
              CMD_WRAP_READ, CMD_FAST_READ: if (s_q.four_line_command_mode) s_d.ph = PH_ADDR;
              CMD_SET_PARAM: begin
                if (s_q.four_line_command_mode) begin
                  s_d.ph = PH_MODE;
                  s_d.cnt = BYTE_CLKS_QUAD;
                end
              end
              default: s_d.ph = PH_DONE;
            endcase
          end
        end
        PH_ADDR: begin
          s_d.addr = na;
          if (s_q.cnt == 5'd1) begin
            case (s_q.cmd)
              CMD_QUAD_ID: begin
                s_d.ph = PH_DATA;
                s_d.sel = {1'b0, na[0]};
              end
              CMD_WORD_READ, CMD_SET_WRAP: begin
                s_d.ph = PH_MODE;
                s_d.cnt = BYTE_CLKS_QUAD;
              end
              default: begin
                s_d.ph = PH_DUMMY;
                s_d.cnt = (s_q.dsel == DUMMY_SEL_LONG) ? DUMMY_LONG : DUMMY_SHORT;
              end
            endcase
          end
        end
        PH_MODE: begin
          if (s_q.cnt == 5'd1) begin
            s_d.ph = PH_DONE;
            case (s_q.cmd)
              CMD_WORD_READ: begin
                s_d.cont = (nb[7:4] == CONT_READ_KEY);
                s_d.ph = PH_DUMMY;
                s_d.cnt = WORD_READ_DUMMY;
              end
              CMD_SET_WRAP: s_d.wrap = nb[WRAP_BITS_LSB +: 3];
              CMD_SET_PARAM: begin
                s_d.dsel = nb[DUMMY_SEL_LSB +: 2];
                s_d.wsel = nb[WRAP_SEL_LSB +: 2];
              end
              default: s_d.ph = PH_DONE;
            endcase
          end
        end
        PH_DUMMY: if (s_q.cnt == 5'd1) s_d.ph = PH_DATA;
        default: s_d.cnt = s_q.cnt;
      endcase
    end else if (fall && s_q.ph == PH_DATA) begin
      // lines stay released until the first data falling edge
      if (s_q.ucnt == 3'd0) begin
        s_d.sh_out = cur_byte;
        s_d.sel = (s_q.cmd == CMD_JEDEC_ID) ? ((s_q.sel == 2'd2) ? 2'd0 : s_q.sel + 2'd1) :
                                              {1'b0, ~s_q.sel[0]};
        s_d.addr = step_addr(s_q.addr, wrap_en, wrap_len);
      end else begin
        s_d.sh_out = single ? {s_q.sh_out[6:0], 1'b0} : {s_q.sh_out[3:0], 4'h0};
      end
      s_d.ucnt = (s_q.ucnt == (single ? 3'd7 : 3'd1)) ? 3'd0 : s_q.ucnt + 3'd1;
      s_d.oe_n = single ? 4'b1101 : 4'b0000;
      s_d.io_out = single ? {2'b00, s_d.sh_out[7], 1'b0} : s_d.sh_out[7:4];
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.sck_m <= 1'b0;
      s_q.cs_m <= 1'b1;
      s_q.cs_r <= 1'b1;
      s_q.oe_n <= 4'hf;
      s_q.ph <= PH_IDLE;
      s_q.four_line_command_mode <= 1'b0;
      s_q.wrap <= WRAP_SETTING_RST;
      s_q.dsel <= DUMMY_SEL_RST;
      s_q.wsel <= WRAP_SEL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.dev_io = s_q.io_out;
  assign link.dev_io_oe_n = s_q.oe_n;
  assign four_line_command_mode_o = s_q.four_line_command_mode;
  assign execute_in_place_o = s_q.cont;
  assign wrap_setting_bits_o = s_q.wrap;
  assign dummy_count_select_o = s_q.dsel;
  assign wrap_size_select_o = s_q.wsel;
endmodule : sflash_dev
`default_nettype wire

// file: verilog/sflash_host.sv
`timescale 1ns/1ps
`default_nettype none
module sflash_host
  import sflash_pkg::*;
#(
  parameter int HALF_CYCLES = SCK_HALF_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  sflash_if.host link,
  input wire logic start_i,
  input wire logic [7:0] op_cmd_i,
  input wire logic op_qpi_i,
  input wire logic op_skip_cmd_i,
  input wire logic op_has_addr_i,
  input wire logic [23:0] op_addr_i,
  input wire logic op_has_xbyte_i,
  input wire logic [7:0] op_xbyte_i,
  input wire logic [3:0] op_dummy_i,
  input wire logic [7:0] op_nbytes_i,
  input wire logic op_rd_quad_i,
  output logic busy_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o
);
  typedef struct packed {
    logic sck;
    logic [7:0] div;
    logic cs_n;
    ph_type ph;
    logic [11:0] cnt;
    logic [23:0] sh;
    logic [3:0] io_out;
    logic [3:0] oe_n;
    logic [3:0] io_m;
    logic [3:0] io_r;
    logic [7:0] rsh;
    logic [2:0] rcnt;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] cmd;
    logic four_line_command_mode;
    logic has_addr;
    logic [23:0] addr;
    logic has_x;
    logic [7:0] xbyte;
    logic [3:0] dummy;
    logic [7:0] nbytes;
    logic rquad;
  } host_state_type;

  host_state_type s_q, s_d;

  // ----------------------------------------------------------------
  // phase entry, skipping phases of zero length
  // ----------------------------------------------------------------
  function automatic host_state_type enter(host_state_type s, ph_type p);
    host_state_type r;
    logic [11:0] len;
    r = s;
    r.ph = p;
    len = 12'd0;
    for (int i = 0; i < 6; i++) begin
      case (r.ph)
        PH_CMD: len = r.four_line_command_mode ? 12'd2 : 12'd8;
        PH_ADDR: len = r.has_addr ? 12'd6 : 12'd0;
        PH_MODE: len = r.has_x ? 12'd2 : 12'd0;
        PH_DUMMY: len = {8'h00, r.dummy};
        PH_DATA: len = r.rquad ? {3'b000, r.nbytes, 1'b0} : {1'b0, r.nbytes, 3'b000};
        default: len = 12'd1;
      endcase
      if (len == 12'd0) begin
        r.ph = ph_type'(r.ph + 3'd1);
      end
    end
    r.cnt = len;
    case (r.ph)
      PH_CMD: begin
        r.sh = {r.cmd, 16'h0000};
        r.oe_n = r.four_line_command_mode ? 4'b0000 : 4'b1110;
      end
      PH_ADDR: begin
        r.sh = r.addr;
        r.oe_n = 4'b0000;
      end
      PH_MODE: begin
        r.sh = {r.xbyte, 16'h0000};
        r.oe_n = 4'b0000;
      end
      PH_DONE: begin
        r.ph = PH_IDLE;
        r.cs_n = 1'b1;
        r.oe_n = 4'hf;
      end
      default: r.oe_n = 4'hf;
    endcase
    enter = r;
  endfunction : enter

  logic one_line;
  assign one_line = (s_q.ph == PH_CMD) && !s_q.four_line_command_mode;

  always_comb begin
    s_d = s_q;
    s_d.io_m = link.io;
    s_d.io_r = s_q.io_m;
    s_d.rvalid = 1'b0;
    if (s_q.ph == PH_IDLE) begin
      if (start_i) begin
        s_d.cmd = op_cmd_i;
        s_d.four_line_command_mode = op_qpi_i;
        s_d.has_addr = op_has_addr_i;
        s_d.addr = op_addr_i;
        s_d.has_x = op_has_xbyte_i;
        s_d.xbyte = op_xbyte_i;
        s_d.dummy = op_dummy_i;
        s_d.nbytes = op_nbytes_i;
        s_d.rquad = op_rd_quad_i;
        s_d.cs_n = 1'b0;
        s_d.div = 8'h00;
        s_d.rcnt = 3'd0;
        s_d = enter(s_d, op_skip_cmd_i ? PH_ADDR : PH_CMD);
      end
    end else if (s_q.div == 8'(HALF_CYCLES - 1)) begin
      s_d.div = 8'h00;
      if (!s_q.sck) begin
        // rising edge: sample, count the clock
        s_d.sck = 1'b1;
        s_d.cnt = s_q.cnt - 12'd1;
        if (s_q.ph == PH_DATA) begin
          s_d.rsh = s_q.rquad ? {s_q.rsh[3:0], s_q.io_r} : {s_q.rsh[6:0], s_q.io_r[1]};
          s_d.rcnt = s_q.rcnt + 3'd1;
          if (s_q.rcnt == (s_q.rquad ? 3'd1 : 3'd7)) begin
            s_d.rcnt = 3'd0;
            s_d.rdata = s_d.rsh;
            s_d.rvalid = 1'b1;
          end
        end
      end else begin
        // falling edge: next unit of output, or next phase
        s_d.sck = 1'b0;
        if (s_q.cnt == 12'd0) begin
          s_d = enter(s_d, ph_type'(s_q.ph + 3'd1));
        end else begin
          s_d.sh = one_line ? {s_q.sh[22:0], 1'b0} : {s_q.sh[19:0], 4'h0};
        end
      end
    end else begin
      s_d.div = s_q.div + 8'h01;
    end
    s_d.io_out = ((s_d.ph == PH_CMD) && !s_d.four_line_command_mode) ? {3'b000, s_d.sh[23]} : s_d.sh[23:20];
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.cs_n <= 1'b1;
      s_q.oe_n <= 4'hf;
      s_q.ph <= PH_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.sck = s_q.sck;
  assign link.cs_n = s_q.cs_n;
  assign link.host_io = s_q.io_out;
  assign link.host_io_oe_n = s_q.oe_n;
  assign busy_o = (s_q.ph != PH_IDLE);
  assign rd_data_o = s_q.rdata;
  assign rd_valid_o = s_q.rvalid;
endmodule : sflash_host
`default_nettype wire
